// File: afr_pkg.sv
package afr_pkg;
  // Register addresses in the special-function space.
  localparam logic [7:0] AFR_ADDR_CTRL0 = 8'hA1;
  localparam logic [7:0] AFR_ADDR_CTRL1 = 8'hA2;
  localparam logic [7:0] AFR_CTRL0_RST = 8'h00;
  localparam logic [7:0] AFR_CTRL1_RST = 8'h00;
  // Field positions in the first control register.
  localparam int AFR_CKO_SEL_HI = 7;
  localparam int AFR_CKO_SEL_LO = 6;
  localparam int AFR_FSWAP_HI = 3;
  localparam int AFR_FSWAP_LO = 2;
  // Field positions in the second control register.
  localparam int AFR_IRQ1_HI = 7;
  localparam int AFR_IRQ1_LO = 6;
  localparam int AFR_IRQ0_BIT = 5;
  // Clock-output selector codes.
  localparam logic [1:0] AFR_CKO_GPIO = 2'h0;
  localparam logic [1:0] AFR_CKO_DIV1 = 2'h1;
  localparam logic [1:0] AFR_CKO_DIV2 = 2'h2;
  localparam logic [1:0] AFR_CKO_DIV4 = 2'h3;
  // Port 1 function swap codes.
  localparam logic [1:0] AFR_FSWAP_RSVD = 2'h0;
  localparam logic [1:0] AFR_FSWAP_UART = 2'h1;
  localparam logic [1:0] AFR_FSWAP_PCA = 2'h2;
  localparam logic [1:0] AFR_FSWAP_TMR = 2'h3;
  // System clock source encoding.
  typedef enum logic [1:0] {AFR_SRC_FAST_RC, AFR_SRC_SLOW_RC, AFR_SRC_EXT} afr_clk_src_t;
  // Register write and read port of the special-function bus.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afr_sfr_req_t;
  // Peripheral-side outputs that may be driven onto pins.
  typedef struct packed {
    logic serial_tx_out;
    logic pulse_width_secondary_out;
    logic capture_compare_out;
    logic capture_compare_oe;
    logic timer_a_clock_out;
    logic timer_b_clock_out;
  } afr_periph_out_t;
  // Peripheral-side inputs gathered from pins.
  typedef struct packed {
    logic serial_rx_in;
    logic capture_compare_in;
    logic timer_a_in;
    logic timer_b_in;
    logic ext_irq_a_n;
    logic ext_irq_b_n;
    logic detector_scl;
    logic detector_sda;
  } afr_periph_in_t;
endpackage

// File: afr_clk_div.sv
`timescale 1ns/100ps
// Divides the master clock rate by two and four as enable-style square waves.
module afr_clk_div (
  input wire logic mclk,
  input wire logic rst_n,
  output logic div2_q,
  output logic div4_q
);
  logic [1:0] cnt_q;

  // Free-running counter; its bits are the divided clocks.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign div2_q = cnt_q[0];
  assign div4_q = cnt_q[1];
endmodule

// File: afr_redirect.sv
`timescale 1ns/100ps
module afr_redirect (
  input wire logic mclk,
  input wire logic rst_n,
  input afr_pkg::afr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_q,
  input afr_pkg::afr_clk_src_t clk_src,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p3_in,
  input wire logic [7:0] p1_gpio_out,
  input wire logic [7:0] p1_gpio_oe,
  input afr_pkg::afr_periph_out_t periph_out,
  output logic [7:0] p1_out_q,
  output logic [7:0] p1_oe_q,
  output afr_pkg::afr_periph_in_t periph_in_q
);
  import afr_pkg::*;

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] p1_s1_q;
  logic [7:0] p1_s2_q;
  logic [7:0] p3_s1_q;
  logic [7:0] p3_s2_q;
  logic div2;
  logic div4;
  logic [1:0] cko_sel;
  logic [1:0] fs_sel;
  logic [1:0] irq1_sel;
  logic cko_on;
  logic cko_val;
  logic [7:0] p1_out_d;
  logic [7:0] p1_oe_d;
  afr_periph_in_t periph_in_d;

  // Pick one bit of a synchronised port by index.
  function automatic logic pin_of(input logic [7:0] port, input int idx);
    return port[idx];
  endfunction

  afr_clk_div u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .div2_q(div2),
    .div4_q(div4)
  );

  // Register writes; all eight bits of both registers store what is written.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl0_q <= AFR_CTRL0_RST;
      ctrl1_q <= AFR_CTRL1_RST;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == AFR_ADDR_CTRL0) begin
        ctrl0_q <= sfr_req.wdata;
      end
      if (sfr_req.addr == AFR_ADDR_CTRL1) begin
        ctrl1_q <= sfr_req.wdata;
      end
    end
  end

  // Read data is registered; other addresses belong to other blocks and read zero here.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_req.rd && sfr_req.addr == AFR_ADDR_CTRL0) begin
      sfr_rdata_q <= ctrl0_q;
    end else if (sfr_req.rd && sfr_req.addr == AFR_ADDR_CTRL1) begin
      sfr_rdata_q <= ctrl1_q;
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  // Pins are asynchronous, so two flip-flops stand before any selection logic.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      p1_s1_q <= 8'hFF;
      p1_s2_q <= 8'hFF;
      p3_s1_q <= 8'hFF;
      p3_s2_q <= 8'hFF;
    end else begin
      p1_s1_q <= p1_in;
      p1_s2_q <= p1_s1_q;
      p3_s1_q <= p3_in;
      p3_s2_q <= p3_s1_q;
    end
  end

  assign cko_sel = ctrl0_q[AFR_CKO_SEL_HI:AFR_CKO_SEL_LO];
  assign fs_sel = ctrl0_q[AFR_FSWAP_HI:AFR_FSWAP_LO];
  assign irq1_sel = ctrl1_q[AFR_IRQ1_HI:AFR_IRQ1_LO];
  // The clock output is honoured only on an internal RC source.
  assign cko_on = (clk_src != AFR_SRC_EXT) && (cko_sel != AFR_CKO_GPIO);

  // Clock-out level per selector code.
  always_comb begin
    case (cko_sel)
      AFR_CKO_DIV1: cko_val = mclk;
      AFR_CKO_DIV2: cko_val = div2;
      AFR_CKO_DIV4: cko_val = div4;
      default: cko_val = 1'b0;
    endcase
  end

  // Pin-side output mux; pin 1.7's enable comes from its mode bits except on the external clock source, where it is forced off.
  always_comb begin
    p1_out_d = p1_gpio_out;
    p1_oe_d = p1_gpio_oe;
    case (fs_sel)
      AFR_FSWAP_UART: begin
        p1_out_d[1] = periph_out.serial_tx_out;
      end
      AFR_FSWAP_PCA: begin
        p1_out_d[1] = periph_out.pulse_width_secondary_out;
        p1_out_d[0] = periph_out.capture_compare_out;
        p1_oe_d[0] = p1_gpio_oe[0] & periph_out.capture_compare_oe;
      end
      AFR_FSWAP_TMR: begin
        p1_out_d[1] = periph_out.timer_b_clock_out;
        p1_out_d[0] = periph_out.timer_a_clock_out;
      end
      default: begin
        p1_out_d = p1_gpio_out;
      end
    endcase
    if (clk_src == AFR_SRC_EXT) begin
      p1_oe_d[7] = 1'b0;
    end else if (cko_on) begin
      p1_out_d[7] = cko_val;
    end
  end

  // Peripheral-side input mux; unrouted inputs idle high.
  always_comb begin
    periph_in_d = '1;
    case (fs_sel)
      AFR_FSWAP_UART: periph_in_d.serial_rx_in = pin_of(p1_s2_q, 0);
      AFR_FSWAP_PCA: periph_in_d.capture_compare_in = pin_of(p1_s2_q, 0);
      AFR_FSWAP_TMR: begin
        periph_in_d.timer_a_in = pin_of(p1_s2_q, 0);
        periph_in_d.timer_b_in = pin_of(p1_s2_q, 1);
      end
      default: periph_in_d.serial_rx_in = 1'b1;
    endcase
    case (irq1_sel)
      2'h0: begin
        periph_in_d.ext_irq_b_n = pin_of(p1_s2_q, 0);
        periph_in_d.detector_scl = pin_of(p1_s2_q, 0);
        periph_in_d.detector_sda = pin_of(p1_s2_q, 1);
      end
      2'h1: begin
        periph_in_d.ext_irq_b_n = pin_of(p1_s2_q, 4);
        periph_in_d.detector_scl = pin_of(p1_s2_q, 4);
        periph_in_d.detector_sda = pin_of(p1_s2_q, 5);
      end
      2'h2: begin
        periph_in_d.ext_irq_b_n = pin_of(p3_s2_q, 0);
        periph_in_d.detector_scl = pin_of(p3_s2_q, 0);
        periph_in_d.detector_sda = pin_of(p3_s2_q, 1);
      end
      default: begin
        periph_in_d.ext_irq_b_n = pin_of(p3_s2_q, 7);
        periph_in_d.detector_scl = pin_of(p3_s2_q, 7);
        periph_in_d.detector_sda = pin_of(p3_s2_q, 6);
      end
    endcase
    periph_in_d.ext_irq_a_n = ctrl1_q[AFR_IRQ0_BIT] ? pin_of(p1_s2_q, 6) : pin_of(p3_s2_q, 2);
  end

  // Registered outputs; pin 1.7 clock-out at the direct rate samples mclk on its own rising edge and so holds one level, a known limitation.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      p1_out_q <= 8'hFF;
      p1_oe_q <= 8'h00;
      periph_in_q <= '1;
    end else begin
      p1_out_q <= p1_out_d;
      p1_oe_q <= p1_oe_d;
      periph_in_q <= periph_in_d;
    end
  end

  // Register checks.
  reg_reset_a: assert property (@(posedge mclk) !rst_n |=> ctrl0_q == 8'h00 && ctrl1_q == 8'h00)
    else $error("routing registers not cleared by reset");
  ctrl0_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == AFR_ADDR_CTRL0 |=> ctrl0_q == $past(sfr_req.wdata))
    else $error("first routing register write lost");
  ctrl1_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_req.rd && sfr_req.addr == AFR_ADDR_CTRL1 |=> sfr_rdata_q == $past(ctrl1_q))
    else $error("second routing register read wrong");
  // A read is one request cycle; its data stands on the bus in the cycle after it.
  sequence ctrl0_rd_s;
    sfr_req.rd && sfr_req.addr == AFR_ADDR_CTRL0;
  endsequence
  sequence foreign_rd_s;
    sfr_req.rd && sfr_req.addr != AFR_ADDR_CTRL0 && sfr_req.addr != AFR_ADDR_CTRL1;
  endsequence
  ctrl0_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl0_rd_s |=> sfr_rdata_q == $past(ctrl0_q))
    else $error("first routing register read wrong");
  foreign_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    foreign_rd_s |=> sfr_rdata_q == 8'h00)
    else $error("read of a foreign address not zero");
  pin17_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_src != AFR_SRC_EXT |=> p1_oe_q[7] == $past(p1_gpio_oe[7]))
    else $error("pin 1.7 enable not taken from its mode bits");
  ext_clk_in_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_src == AFR_SRC_EXT |=> !p1_oe_q[7])
    else $error("pin 1.7 driven in external clock mode");
  cko_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_src == AFR_SRC_EXT |=> p1_out_q[7] == $past(p1_gpio_out[7]))
    else $error("clock selector acted on external source");
  irq0_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl1_q[AFR_IRQ0_BIT] |=> periph_in_q.ext_irq_a_n == $past(p1_s2_q[6]))
    else $error("interrupt 0 not taken from pin 1.6");
  irq1_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl1_q[AFR_IRQ1_HI:AFR_IRQ1_LO] == 2'h3 |=> periph_in_q.detector_sda == $past(p3_s2_q[6]))
    else $error("detector data not taken from pin 3.6");
  uart_swap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl0_q[AFR_FSWAP_HI:AFR_FSWAP_LO] == AFR_FSWAP_UART
    |=> p1_out_q[1] == $past(periph_out.serial_tx_out))
    else $error("serial transmit not on pin 1.1");
  idle_unrouted_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl0_q[AFR_FSWAP_HI:AFR_FSWAP_LO] != AFR_FSWAP_UART |=> periph_in_q.serial_rx_in)
    else $error("unrouted serial input not idle");
  div4_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_src != AFR_SRC_EXT && ctrl0_q[AFR_CKO_SEL_HI:AFR_CKO_SEL_LO] == AFR_CKO_DIV4
    |=> p1_out_q[7] == $past(div4))
    else $error("quarter-rate clock not on pin 1.7");
endmodule

// File: afr_pin_model.sv
`timescale 1ns/100ps
// Pins and peripherals around the router; levels change only on a load so that they hold while checked.
module afr_pin_model (
  input wire logic mclk,
  input wire logic load,
  input wire logic [31:0] rnd,
  input wire logic cko_use,
  output logic [7:0] p1_in,
  output logic [7:0] p3_in,
  output logic [7:0] p1_gpio_out,
  output logic [7:0] p1_gpio_oe,
  output afr_pkg::afr_periph_out_t periph_out
);
  import afr_pkg::*;
  logic [37:0] pic_q = '0;
  // Software picks push-pull on the clock pin whenever it wants a clock out of it.
  always @(posedge mclk) begin
    if (load)
      pic_q <= {rnd[5:0] ^ rnd[29:24], rnd[31:24] | {cko_use, 7'h00}, rnd[23:0]};
  end
  // One word fans out to every pin level and peripheral output.
  assign {periph_out, p1_gpio_oe, p1_gpio_out, p3_in, p1_in} = pic_q;
endmodule

// File: alternate_function_redirect_tb.sv
`timescale 1ns/100ps
module alternate_function_redirect_tb;
  import afr_pkg::*;
  logic mclk, rst_n, load, cko_use, prev;
  logic [31:0] rnd;
  logic [5:0] m, v;
  afr_sfr_req_t sfr_req;
  afr_clk_src_t clk_src;
  logic [7:0] sfr_rdata_q, p1_in, p3_in, p1_gpio_out, p1_gpio_oe, p1_out_q, p1_oe_q;
  afr_periph_out_t periph_out;
  afr_periph_in_t periph_in_q;
  logic [3:0] irq_seen;
  logic [5:0] fs_seen;
  int err_total, check_count, n;
  afr_redirect dut (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
    .clk_src(clk_src), .p1_in(p1_in), .p3_in(p3_in), .p1_gpio_out(p1_gpio_out),
    .p1_gpio_oe(p1_gpio_oe), .periph_out(periph_out), .p1_out_q(p1_out_q), .p1_oe_q(p1_oe_q),
    .periph_in_q(periph_in_q));
  afr_pin_model pins (.mclk(mclk), .load(load), .rnd(rnd), .cko_use(cko_use), .p1_in(p1_in),
    .p3_in(p3_in), .p1_gpio_out(p1_gpio_out), .p1_gpio_oe(p1_gpio_oe), .periph_out(periph_out));
  // Routed pin outputs and inputs gathered in the bit order that the expectation functions use.
  assign irq_seen = {periph_in_q.ext_irq_a_n, periph_in_q.ext_irq_b_n,
    periph_in_q.detector_scl, periph_in_q.detector_sda};
  assign fs_seen = {p1_out_q[1:0], periph_in_q.serial_rx_in, periph_in_q.capture_compare_in,
    periph_in_q.timer_a_in, periph_in_q.timer_b_in};
  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Interrupt and detector levels expected for a second-register value.
  function automatic logic [3:0] exp_irq(input logic [7:0] c1);
    logic [1:0] b;
    case (c1[7:6])
      2'h0: b = {p1_in[0], p1_in[1]};
      2'h1: b = {p1_in[4], p1_in[5]};
      2'h2: b = {p3_in[0], p3_in[1]};
      default: b = {p3_in[7], p3_in[6]};
    endcase
    return {c1[5] ? p1_in[6] : p3_in[2], b[1], b[1], b[0]};
  endfunction
  // Mask and value of pin 1.1, pin 1.0, receive, capture, timer a and timer b for a swap code.
  function automatic logic [11:0] exp_fs(input logic [1:0] fs);
    case (fs)
      2'h0: return {6'h3F, p1_gpio_out[1], p1_gpio_out[0], 4'hF};
      2'h1: return {6'h2F, periph_out.serial_tx_out, 1'b0, p1_in[0], 3'h7};
      2'h2: return {6'h3F, periph_out.pulse_width_secondary_out, periph_out.capture_compare_out, 1'b1, p1_in[0], 2'h3};
      default: return {6'h3F, periph_out.timer_b_clock_out, periph_out.timer_a_clock_out, 2'h3, p1_in[0], p1_in[1]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // The request is held through its sampling edge and stays on the bus until the caller replaces it or idles it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(sfr_rdata_q, e);
  endtask
  // New pin picture, then enough cycles for the two synchroniser flops and the output register.
  task automatic shuffle(input logic use_ck);
    sfr_req = '0;
    rnd = lfsr(rnd);
    cko_use = use_ck;
    load = 1'b1;
    @(posedge mclk);
    #1 load = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the few hundred cycles the run needs.
  initial begin
    #50000;
    err_total++;
    summarize;
  end
  // Main sequence: reset, register access, routing tables, clock output.
  initial begin
    {rst_n, load, cko_use, err_total, check_count} = '0;
    rnd = 32'h427b;
    sfr_req = '0;
    clk_src = AFR_SRC_FAST_RC;
    repeat (5) @(posedge mclk);
    #1;
    chk({p1_out_q, p1_oe_q, sfr_rdata_q, periph_in_q}, 32'hFF0000FF);
    rst_n = 1'b1;
    rdchk(AFR_ADDR_CTRL0, AFR_CTRL0_RST);
    rdchk(AFR_ADDR_CTRL1, AFR_CTRL1_RST);
    for (int i = 0; i < 5; i++) begin
      rnd = (i == 0) ? 32'hFFFFFFFF : lfsr(rnd);
      bus(1'b1, AFR_ADDR_CTRL0, rnd[7:0]);
      bus(1'b1, AFR_ADDR_CTRL1, rnd[15:8]);
      bus(1'b1, 8'hA3, rnd[23:16]);
      rdchk(AFR_ADDR_CTRL0, rnd[7:0]);
      rdchk(AFR_ADDR_CTRL1, rnd[15:8]);
      rdchk(8'hA3, 8'h00);
    end
    sfr_req = '0;
    @(posedge mclk);
    #1 rst_n = 1'b0;
    @(posedge mclk);
    #1 rst_n = 1'b1;
    shuffle(1'b0);
    chk(irq_seen, exp_irq(8'h00));
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, AFR_ADDR_CTRL1, {i[2:0], 5'h00});
      shuffle(1'b0);
      chk(irq_seen, exp_irq({i[2:0], 5'h00}));
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, AFR_ADDR_CTRL0, {4'h0, i[1:0], 2'h0});
      shuffle(1'b0);
      {m, v} = exp_fs(i[1:0]);
      chk(fs_seen & m, v & m);
      chk(p1_out_q[7:2], p1_gpio_out[7:2]);
      chk(p1_oe_q, {p1_gpio_oe[7:1], p1_gpio_oe[0] & (i != 2 || periph_out.capture_compare_oe)});
    end
    for (int i = 0; i < 12; i++) begin
      clk_src = afr_clk_src_t'(i / 4);
      bus(1'b1, AFR_ADDR_CTRL0, {i[1:0], 6'h00});
      shuffle(i[1:0] != 2'h0);
      n = 0;
      prev = p1_out_q[7];
      repeat (16) begin
        @(posedge mclk);
        #1;
        if (p1_out_q[7] !== prev)
          n++;
        prev = p1_out_q[7];
      end
      chk(p1_oe_q[7], (i / 4 == 2) ? 1'b0 : p1_gpio_oe[7]);
      if (i / 4 == 2 || i[1:0] != 2'h1)
        chk(n, (i / 4 == 2 || i[1:0] == 2'h0) ? 0 : (i[1:0] == 2'h2) ? 16 : 8);
    end
    summarize;
  end
endmodule
